// file: sleep_ctl_regs.svh
// register offsets, field positions, reset values and encodings of the mode controller
`ifndef SLEEP_CTL_REGS_SVH
`define SLEEP_CTL_REGS_SVH

// register indices (word addresses on the plain port)
`define REG_CTRL        4'h0
`define REG_FUN         4'h1
`define REG_STATUS      4'h2
`define REG_CMD         4'h3
`define REG_EVENTS      4'h4

// control register fields
`define CTRL_SCLK_BIT   0
`define CTRL_APPOL_BIT  1
`define CTRL_AIRCTL_BIT 2
`define CTRL_LINK_LSB   3
`define CTRL_LINK_MSB   4
`define CTRL_RESET      32'h0000_0000

// functionality levels
`define FUN_MIN         3'h0
`define FUN_FULL        3'h1
`define FUN_AIR         3'h4

// command register fields
`define CMD_RF_BIT      0
`define CMD_REPORT_BIT  1

// host link kinds held in the control register
`define LINK_UART       2'h0
`define LINK_USB_RWU    2'h1
`define LINK_USB_RI     2'h2
`define LINK_USB_NOSUSP 2'h3

`endif

// file: sleep_ctl_pkg.sv
// types shared by the mode controller files
`default_nettype none
package sleep_ctl_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SLEEP,
      ST_WAKE
   } power_state_t;
endpackage
`default_nettype wire

// file: wake_if.sv
// wake-request signals passed from the sleep core up to the top
`default_nettype none
interface wake_if;
   logic sleeping;
   logic wake_event;
   logic host_wake_ri;
   logic host_wake_usb;
   modport core (output sleeping, output wake_event, output host_wake_ri, output host_wake_usb);
   modport top  (input  sleeping, input  wake_event, input  host_wake_ri, input  host_wake_usb);
endinterface
`default_nettype wire

// file: sleep_core.sv
// sleep entry and wake state machine for the host link
`default_nettype none
`include "sleep_ctl_regs.svh"
module sleep_core
   import sleep_ctl_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // conditions, already synchronised
   input  wire logic       sclk_en,
   input  wire logic [1:0] link,
   input  wire logic       dtr_high,
   input  wire logic       usb_suspended,
   input  wire logic       vbus_present,
   input  wire logic       usb_rx,
   input  wire logic       report_pending,
   input  wire logic       host_asleep,
   // results
   wake_if.core            w
);
   power_state_t state;
   logic         enter_ok;
   logic         wake_now;

   // entry conditions per host link
   always_comb begin
      case (link)
         `LINK_UART:       enter_ok = sclk_en && dtr_high;
         `LINK_USB_RWU,
         `LINK_USB_RI:     enter_ok = sclk_en && dtr_high && usb_suspended;
         `LINK_USB_NOSUSP: enter_ok = sclk_en && dtr_high && !vbus_present;
         default:          enter_ok = 1'b0;
      endcase
   end

   // wake sources per host link
   always_comb begin
      case (link)
         `LINK_UART:       wake_now = !dtr_high;
         `LINK_USB_RWU,
         `LINK_USB_RI:     wake_now = !dtr_high || usb_rx || !usb_suspended;
         `LINK_USB_NOSUSP: wake_now = !dtr_high || vbus_present;
         default:          wake_now = 1'b1;
      endcase
   end

   // sleep state: network paging continues, so only the host side sleeps
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE:  if (enter_ok) state <= ST_SLEEP;
            ST_SLEEP: if (wake_now) state <= ST_WAKE;
            ST_WAKE:  if (!enter_ok) state <= ST_IDLE;       // re-arm only after conditions drop
            default:  state <= ST_IDLE;
         endcase
      end
   end

   assign w.sleeping      = (state == ST_SLEEP);
   assign w.wake_event    = (state == ST_SLEEP) && wake_now;
   // host wake paths, only while the host reports sleep
   assign w.host_wake_ri  = report_pending && host_asleep && (link != `LINK_USB_RWU);
   assign w.host_wake_usb = report_pending && host_asleep && (link == `LINK_USB_RWU)
                            && usb_suspended;
endmodule // sleep_core
`default_nettype wire

// file: sleep_airplane_mode_control.sv
// operating-mode controller: sleep entry, wake paths, airplane and minimum modes
`default_nettype none
`include "sleep_ctl_regs.svh"
module sleep_airplane_mode_control
   import sleep_ctl_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // register port
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   // host link pins, asynchronous
   input  wire logic        dtr_n_high,
   input  wire logic        host_sleep_detect,
   input  wire logic        rf_disable_n,
   input  wire logic        usb_suspend,
   input  wire logic        usb_vbus,
   input  wire logic        usb_rx_activity,
   // module-side event
   input  wire logic        power_down_req,
   // outputs
   output logic             ri,
   output logic             usb_remote_wakeup,
   output logic             sleep_mode,
   output logic             rf_enable,
   output logic             sim_enable,
   output logic             gnss_enable,
   output logic             core_supply_en,
   output logic             serial_enable
);
   // ========================================================
   // pin synchronisers
   // ========================================================
   localparam int NSYNC = 6;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] sync_a;
   logic [NSYNC-1:0] sync_b;
   assign pin_raw = {usb_rx_activity, usb_vbus, usb_suspend,
                     rf_disable_n, host_sleep_detect, dtr_n_high};

   // two flops each; the first stage feeds only the second
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               sync_a[gi] <= 1'b0;
               sync_b[gi] <= 1'b0;
            end else begin
               sync_a[gi] <= pin_raw[gi];
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate

   logic dtr_high;
   logic hsd;
   logic rfdis_n;
   logic usb_susp;
   logic vbus;
   logic usb_rx;
   assign dtr_high = sync_b[0];
   assign hsd      = sync_b[1];
   assign rfdis_n  = sync_b[2];
   assign usb_susp = sync_b[3];
   assign vbus     = sync_b[4];
   assign usb_rx   = sync_b[5];

   // ========================================================
   // registers
   // ========================================================
   logic       sclk_en;
   logic       ap_pol;
   logic       air_ctl;
   logic [1:0] link;
   logic [2:0] fun;
   logic       report_pending;
   logic       rf_refused;
   logic       powered_down;
   logic       wake_seen;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
      hit = (a == r);
   endfunction

   // control register: sleep enable, detect polarity, pin control, link kind
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sclk_en <= 1'b0;
         ap_pol  <= 1'b0;
         air_ctl <= 1'b0;
         link    <= `LINK_UART;
      end else if (wr && hit(addr, `REG_CTRL) && !powered_down) begin
         sclk_en <= wdata[`CTRL_SCLK_BIT];
         ap_pol  <= wdata[`CTRL_APPOL_BIT];
         air_ctl <= wdata[`CTRL_AIRCTL_BIT];
         link    <= wdata[`CTRL_LINK_MSB:`CTRL_LINK_LSB];
      end
   end

   // functionality level; undefined codes are ignored
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fun <= `FUN_FULL;
      end else if (wr && hit(addr, `REG_FUN) && !powered_down) begin
         if (wdata[2:0] == `FUN_MIN || wdata[2:0] == `FUN_FULL || wdata[2:0] == `FUN_AIR)
            fun <= wdata[2:0];
      end
   end

   logic airplane;
   assign airplane = (fun == `FUN_AIR) || (fun == `FUN_MIN)
                     || (air_ctl && !rfdis_n);

   // report pending flag: set wins over the clear by read
   logic report_set;
   logic events_clr;
   assign report_set = wr && hit(addr, `REG_CMD) && wdata[`CMD_REPORT_BIT] && !powered_down;
   assign events_clr = rd && hit(addr, `REG_EVENTS);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         report_pending <= 1'b0;
      end else if (report_set) begin
         report_pending <= 1'b1;
      end else if (events_clr) begin
         report_pending <= 1'b0;
      end
   end

   // sticky refusal of rf commands while rf is off
   logic rf_cmd;
   assign rf_cmd = wr && hit(addr, `REG_CMD) && wdata[`CMD_RF_BIT];
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rf_refused <= 1'b0;
      end else if (rf_cmd && airplane) begin
         rf_refused <= 1'b1;
      end else if (events_clr) begin
         rf_refused <= 1'b0;
      end
   end

   // power-down latch: only reset brings the module back
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         powered_down <= 1'b0;
      end else if (power_down_req) begin
         powered_down <= 1'b1;
      end
   end

   // ========================================================
   // sleep core
   // ========================================================
   wake_if w ();
   logic host_asleep;
   assign host_asleep = ap_pol ? hsd : !hsd;

   sleep_core u_core (
      .clk           (clk),
      .rstn          (rstn),
      .sclk_en       (sclk_en && !powered_down),
      .link          (link),
      .dtr_high      (dtr_high),
      .usb_suspended (usb_susp),
      .vbus_present  (vbus),
      .usb_rx        (usb_rx),
      .report_pending (report_pending),
      .host_asleep   (host_asleep),
      .w             (w.core)
   );

   // wake event seen, cleared by reading the event register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wake_seen <= 1'b0;
      end else if (w.wake_event) begin
         wake_seen <= 1'b1;
      end else if (events_clr) begin
         wake_seen <= 1'b0;
      end
   end

   // ========================================================
   // outputs, all registered
   // ========================================================
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ri                <= 1'b0;
         usb_remote_wakeup <= 1'b0;
         sleep_mode        <= 1'b0;
      end else begin
         ri                <= w.host_wake_ri && !powered_down;
         usb_remote_wakeup <= w.host_wake_usb && !powered_down;
         sleep_mode        <= w.sleeping && !powered_down;
      end
   end

   // rf and sim gating; positioning follows only power-down
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rf_enable      <= 1'b0;
         sim_enable     <= 1'b0;
         gnss_enable    <= 1'b0;
         core_supply_en <= 1'b0;
         serial_enable  <= 1'b0;
      end else begin
         rf_enable      <= !airplane && !powered_down;
         sim_enable     <= (fun != `FUN_MIN) && !powered_down;
         gnss_enable    <= !powered_down;
         core_supply_en <= !powered_down;
         serial_enable  <= !powered_down;
      end
   end

   // read data one cycle after the strobe; silent in power-down
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= 32'h0000_0000;
         if (rd && !powered_down) begin
            case (addr)
               `REG_CTRL:   rdata <= {27'h0, link, air_ctl, ap_pol, sclk_en};
               `REG_FUN:    rdata <= {29'h0, fun};
               `REG_STATUS: rdata <= {25'h0, host_asleep, airplane, usb_susp,
                                      vbus, dtr_high, rfdis_n, w.sleeping};
               `REG_EVENTS: rdata <= {29'h0, wake_seen, report_pending, rf_refused};
               default:     rdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // sleep_airplane_mode_control
`default_nettype wire

// file: sleep_ctl_props.sv
// concurrent checks on the mode controller ports
`default_nettype none
module sleep_ctl_props (
   // clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // watched inputs
   input wire logic        rd,
   input wire logic        dtr_n_high,
   input wire logic        usb_vbus,
   input wire logic        usb_rx_activity,
   input wire logic        power_down_req,
   // watched outputs
   input wire logic [31:0] rdata,
   input wire logic        ri,
   input wire logic        usb_remote_wakeup,
   input wire logic        sleep_mode,
   input wire logic        rf_enable,
   input wire logic        sim_enable,
   input wire logic        gnss_enable,
   input wire logic        core_supply_en
);
   // ====================
   // properties
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // read data only stands in the slot after a read strobe
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("rdata not zero outside read slot");
   a_sleep_dtr: assert property ($rose(sleep_mode) |-> $past(dtr_n_high, 3))
      else $error("sleep entered without dtr high");
   a_wake_dtr: assert property (sleep_mode && $fell(dtr_n_high) |-> ##[1:6] !sleep_mode)
      else $error("no wake after dtr low");
   a_wake_rx: assert property (sleep_mode && $rose(usb_rx_activity) |-> ##[1:6] !sleep_mode)
      else $error("no wake after usb data");
   a_wake_vbus: assert property (sleep_mode && $rose(usb_vbus) |-> ##[1:6] !sleep_mode)
      else $error("no wake after vbus return");
   a_gnss_kept: assert property (core_supply_en |-> gnss_enable)
      else $error("positioning lost while powered");
   a_sim_rf: assert property (core_supply_en && !sim_enable |-> !rf_enable)
      else $error("rf on while sim off");
   a_pd_entry: assert property (power_down_req |-> ##[1:3] !core_supply_en)
      else $error("power down not entered");
   a_pd_hold: assert property ($past(rstn) && !core_supply_en |=> !core_supply_en)
      else $error("power down left without reset");
   a_wake_excl: assert property (ri |-> !usb_remote_wakeup)
      else $error("ri and remote wakeup together");
   // main scenarios
   c_sleep: cover property ($rose(sleep_mode));
   c_ri: cover property ($rose(ri));
   c_rwu: cover property ($rose(usb_remote_wakeup));
   c_pd: cover property ($fell(core_supply_en));
endmodule // sleep_ctl_props
bind sleep_airplane_mode_control sleep_ctl_props i_props (
   .clk(clk), .rstn(rstn), .rd(rd), .dtr_n_high(dtr_n_high), .usb_vbus(usb_vbus),
   .usb_rx_activity(usb_rx_activity), .power_down_req(power_down_req), .rdata(rdata),
   .ri(ri), .usb_remote_wakeup(usb_remote_wakeup), .sleep_mode(sleep_mode),
   .rf_enable(rf_enable), .sim_enable(sim_enable), .gnss_enable(gnss_enable),
   .core_supply_en(core_supply_en)
);
`default_nettype wire

// file: host_model.sv
// behavioural host processor on the far side of the link pins
`default_nettype none
module host_model (
   // clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // bench request and module wake lines
   input  wire logic want_sleep,
   input  wire logic ri,
   input  wire logic usb_remote_wakeup,
   // link pins
   output logic      dtr_n_high,
   output logic      host_sleep_detect,
   output logic      usb_suspend
);
   timeunit 1ns;
   timeprecision 1ns;
   logic asleep;
   logic want_q;
   // sleeps only on a fresh request, so a woken host does not fall straight back asleep
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         asleep <= 1'b0;
         want_q <= 1'b0;
      end else begin
         want_q <= want_sleep;
         if (ri || usb_remote_wakeup || !want_sleep) asleep <= 1'b0;
         else if (!want_q) asleep <= 1'b1;
      end
   end
   // a sleeping host parks dtr high and suspends the bus; waking drops both
   assign dtr_n_high = asleep;
   assign usb_suspend = asleep;
   assign host_sleep_detect = asleep;
endmodule // host_model
`default_nettype wire

// file: sleep_airplane_mode_control_tb_top.sv
// self-checking bench for the mode controller
`default_nettype none
`include "sleep_ctl_regs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
   $display("unexpected %s exp %0h got %0h", n, e, g); end end
module sleep_airplane_mode_control_tb_top
   import sleep_ctl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rstn, wr, rd, rf_disable_n, usb_vbus, usb_rx_activity, power_down_req;
   logic        dtr_n_high, host_sleep_detect, usb_suspend, ri, usb_remote_wakeup;
   logic        sleep_mode, rf_enable, sim_enable, gnss_enable, core_supply_en, serial_enable;
   logic        want_sleep, seen_ri, seen_rwu;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata, v;
   logic [2:0]  nv, fun;
   logic [7:0]  lfsr;
   int          fails, cmp_count;
   logic [2:0]  tbl [3] = '{`FUN_MIN, `FUN_AIR, `FUN_FULL};
   // ====================
   // design and host
   sleep_airplane_mode_control i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .dtr_n_high(dtr_n_high),
      .host_sleep_detect(host_sleep_detect), .rf_disable_n(rf_disable_n),
      .usb_suspend(usb_suspend), .usb_vbus(usb_vbus), .usb_rx_activity(usb_rx_activity),
      .power_down_req(power_down_req), .ri(ri), .usb_remote_wakeup(usb_remote_wakeup),
      .sleep_mode(sleep_mode), .rf_enable(rf_enable), .sim_enable(sim_enable),
      .gnss_enable(gnss_enable), .core_supply_en(core_supply_en),
      .serial_enable(serial_enable));
   host_model i_host (.clk(clk), .rstn(rstn), .want_sleep(want_sleep), .ri(ri),
      .usb_remote_wakeup(usb_remote_wakeup), .dtr_n_high(dtr_n_high),
      .host_sleep_detect(host_sleep_detect), .usb_suspend(usb_suspend));
   // ====================
   // helpers
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // illegal levels leave the current one in place
   function automatic logic [2:0] exp_fun(input logic [2:0] cur, input logic [2:0] n);
      return (n == `FUN_MIN || n == `FUN_FULL || n == `FUN_AIR) ? n : cur;
   endfunction
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] q);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 q = rdata;
   endtask
   // bounded wait that also records wake pulses towards the host
   task automatic wait_sleep(input logic s);
      for (int i = 0; i < 40 && sleep_mode !== s; i++) begin
         idle(1);
         seen_ri |= ri;
         seen_rwu |= usb_remote_wakeup;
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ====================
   // clock and watchdog
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #200000;
      fails++;
      close_out();
   end
   // ====================
   // main sequence
   initial begin
      {rstn, wr, rd, usb_rx_activity, power_down_req, want_sleep} = '0;
      {rf_disable_n, usb_vbus} = 2'b11;
      addr = 4'h0;
      wdata = 32'h0;
      lfsr = 8'h14;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      rd_reg(`REG_FUN, v);
      `CHK("fun reset", 32'h1, v)
      rd_reg(4'hF, v);
      `CHK("unmapped", 32'h0, v)
      // levels from a fixed table, then random ones including illegal codes
      fun = `FUN_FULL;
      for (int i = 0; i < 10; i++) begin
         lfsr = lfsr_next(lfsr);
         nv = (i < 3) ? tbl[i] : lfsr[2:0];
         fun = exp_fun(fun, nv);
         wr_reg(`REG_FUN, {29'h0, nv});
         rd_reg(`REG_FUN, v);
         `CHK("fun", {29'h0, fun}, v)
         `CHK("sim", fun != `FUN_MIN, sim_enable)
         `CHK("rf", fun == `FUN_FULL, rf_enable)
         `CHK("gnss", 1'b1, gnss_enable)
         wr_reg(`REG_CMD, 32'h1);
         rd_reg(`REG_EVENTS, v);
         `CHK("refused", fun != `FUN_FULL, v[0])
      end
      wr_reg(`REG_FUN, 32'h1);
      // the pin is ignored until pin control is switched on
      rf_disable_n <= 1'b0;
      idle(6);
      `CHK("rf pin off", 1'b1, rf_enable)
      wr_reg(`REG_CTRL, 32'h4);
      idle(6);
      `CHK("rf pin on", 1'b0, rf_enable)
      wr_reg(`REG_CMD, 32'h1);
      rd_reg(`REG_EVENTS, v);
      `CHK("pin refused", 32'h1, v)
      rf_disable_n <= 1'b1;
      wr_reg(`REG_CTRL, 32'h0);
      // every host link: no sleep without enable, sleep, then its own wake path
      for (int k = 0; k < 4; k++) begin
         want_sleep <= 1'b1;
         usb_vbus <= (k != 3);
         idle(12);
         `CHK("no sleep", 1'b0, sleep_mode)
         wr_reg(`REG_CTRL, 32'h3 | (k << 3));
         wait_sleep(1'b1);
         `CHK("sleep", 1'b1, sleep_mode)
         `CHK("rf in sleep", 1'b1, rf_enable)
         rd_reg(`REG_STATUS, v);
         `CHK("status", 32'h41, v & 32'h41)
         seen_ri = 1'b0;
         seen_rwu = 1'b0;
         if (k < 2) wr_reg(`REG_CMD, 32'h2);
         else if (k == 2) usb_rx_activity <= 1'b1;
         else usb_vbus <= 1'b1;
         wait_sleep(1'b0);
         `CHK("woken", 1'b0, sleep_mode)
         `CHK("ri", k == 0, seen_ri)
         `CHK("rwu", k == 1, seen_rwu)
         rd_reg(`REG_EVENTS, v);
         `CHK("events", (k < 2) ? 32'h6 : 32'h4, v)
         usb_rx_activity <= 1'b0;
         want_sleep <= 1'b0;
         wr_reg(`REG_CTRL, 32'h0);
         idle(8);
      end
      // low detect level now means the awake host reads as asleep
      rd_reg(`REG_STATUS, v);
      `CHK("detect low", 1'b1, v[6])
      @(posedge clk);
      power_down_req <= 1'b1;
      @(posedge clk);
      power_down_req <= 1'b0;
      idle(4);
      `CHK("core supply", 1'b0, core_supply_en)
      `CHK("serial", 1'b0, serial_enable)
      rd_reg(`REG_FUN, v);
      `CHK("silent read", 32'h0, v)
      close_out();
   end
endmodule // sleep_airplane_mode_control_tb_top
`default_nettype wire
